// ### hdl/ext_timer_inputs.sv
/*
 * External count-clock inputs of four 16-bit timers and clear inputs of timers 1 and 2, with
 * an APB4 slave holding the edge configuration and the counts, and a
 * tick out to the serial baud-rate generator taken from timer 2's pin.
 * Assumes pins are synchronous-safe levels slower than the core clock.
 */
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (RULE1) Timer 1 counts up or down on chosen edges of its count pin.
// (RULE2) Timer 2 counts up or down on chosen edges of its count pin.
// (RULE3) Timer 2 count pin may also clock the serial baud generator.
// (RULE4) Timer 3 counts up or down on chosen edges of its count pin.
// (RULE5) Timer 4 counts up or down on chosen edges of its count pin.
// (RULE6) Timer 1 clears on chosen edges of its clear pin.
// (RULE7) Timer 2 clears on chosen edges of its clear pin.
// (RULE8) Pins are synchronised first; each edge acts exactly once.
module ext_timer_inputs (
    input wire logic i_core_clk, // 125 MHz core clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB access phase
    input wire logic i_pwrite, // APB direction
    input wire logic [11:0] i_paddr, // APB byte address
    input wire logic [31:0] i_pwdata, // APB write data
    input wire logic [3:0] i_pstrb, // APB byte strobes
    output logic [31:0] o_prdata, // APB read data
    output logic o_pready, // APB ready
    output logic o_pslverr, // APB error, unmapped address
    input wire logic i_timer_one_ext_count_in, // Timer 1 count pin
    input wire logic i_timer_two_ext_count_in, // Timer 2 count pin
    input wire logic i_timer_three_ext_count_in, // Timer 3 count pin
    input wire logic i_timer_four_ext_count_in, // Timer 4 count pin
    input wire logic i_timer_one_ext_clear_in, // Timer 1 clear pin
    input wire logic i_timer_two_ext_clear_in, // Timer 2 clear pin
    output logic o_baud_ext_tick, // Baud generator clock pulse
    output logic [63:0] o_timer_counts // Counts, timer 1 lowest
);
    localparam int unsigned NT = ext_timer_pkg::N_TIMERS;
    localparam int unsigned NC = ext_timer_pkg::N_CLEAR;
    localparam int unsigned CW = ext_timer_pkg::CNT_W;
    localparam int unsigned BW = ext_timer_pkg::CFG_W;

    // ***************************************************************
    // Elaboration checks
    // ***************************************************************
    // Read and load paths pad each count to one 16-bit lane pair
    if (CW != 16 || NT * CW != 64 || NC > NT)
    begin : g_bad_sizes
        $error("ext_timer_inputs: sizes do not fit the port map");
    end

    // Every timer needs a whole config byte inside the one CFG word
    if (BW * NT > 32 || $bits(ext_timer_pkg::tmr_cfg_s) != BW)
    begin : g_bad_cfg
        $error("ext_timer_inputs: config bytes do not fit CFG");
    end

    // ***************************************************************
    // Declarations
    // ***************************************************************
    ext_timer_pkg::apb_req_s req;
    ext_timer_pkg::tmr_cfg_s cfg [NT];
    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic baud_r;
    logic baud_nxt;
    logic commit;
    logic [NT-1:0] load;
    logic [CW-1:0] load_val [NT];
    logic [NT-1:0] cnt_hit;
    logic [NT-1:0] clr_hit;
    logic [NT-1:0] pin_cnt;
    logic [NC-1:0] pin_clr;
    logic [CW-1:0] count [NT];

    // ***************************************************************
    // Helpers
    // ***************************************************************
    // Index of a count register, or NT when the address is not one
    function automatic logic [2:0] cnt_index(input logic [11:0] a);
        logic [2:0] idx;
        idx = 3'(NT);
        unique case (a)
            ext_timer_pkg::OFF_CNT1: idx = 3'h0;
            ext_timer_pkg::OFF_CNT2: idx = 3'h1;
            ext_timer_pkg::OFF_CNT3: idx = 3'h2;
            ext_timer_pkg::OFF_CNT4: idx = 3'h3;
            default: idx = 3'(NT);
        endcase
        return idx;
    endfunction : cnt_index

    // Byte-lane merge under APB strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++)
        begin
            if (st[b])
            begin
                m[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return m;
    endfunction : merge

    // ***************************************************************
    // Pin qualification
    // ***************************************************************
    assign req = '{addr: i_paddr, write: i_pwrite,
                   wdata: i_pwdata, strb: i_pstrb};
    assign pin_cnt = {i_timer_four_ext_count_in,
                      i_timer_three_ext_count_in,
                      i_timer_two_ext_count_in,
                      i_timer_one_ext_count_in};
    assign pin_clr = {i_timer_two_ext_clear_in,
                      i_timer_one_ext_clear_in};

    for (genvar t = 0; t < NT; t++)
    begin : g_timer
        assign cfg[t] = ext_timer_pkg::tmr_cfg_s'(cfg_r[BW*t +: BW]);

        // Count pin edges for timers 1..4 [RULE1] [RULE2] [RULE4] [RULE5]
        pin_edge_qualify u_cnt_edge (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_pin(pin_cnt[t]),
            .i_sel(cfg[t].cnt_edge),
            .o_hit(cnt_hit[t])
        );

        if (t < NC)
        begin : g_clear
            // Clear pin edges for timers 1 and 2 [RULE6] [RULE7]
            pin_edge_qualify u_clr_edge (
                .i_core_clk(i_core_clk),
                .i_nrst(i_nrst),
                .i_pin(pin_clr[t]),
                .i_sel(cfg[t].clr_edge),
                .o_hit(clr_hit[t])
            );
        end
        else
        begin : g_no_clear
            // Timers 3 and 4 have no clear pin in this block
            assign clr_hit[t] = 1'b0;
        end

        // Direction and enable from software [RULE1] [RULE2] [RULE4]
        updown_counter #(
            .WIDTH(CW)
        ) u_count (
            .i_core_clk(i_core_clk),
            .i_nrst(i_nrst),
            .i_en(cfg[t].en),
            .i_up(cfg[t].up),
            .i_step(cnt_hit[t]), // [RULE5] [RULE8]
            .i_clear(clr_hit[t]), // [RULE6] [RULE7]
            .i_load(load[t]),
            .i_load_val(load_val[t]),
            .o_count(count[t])
        );

        assign o_timer_counts[CW*t +: CW] = count[t];
    end

    // ***************************************************************
    // Baud-rate generator clock
    // ***************************************************************
    // Follows timer 2's edge choice but not its enable, so the baud
    // source keeps running while timer 2 itself is stopped.
    always_comb
    begin
        baud_nxt = cfg[1].baud_sel && cnt_hit[1]; // [RULE3]
    end

    // ***************************************************************
    // APB slave
    // ***************************************************************
    // One wait state: ready rises in the second access cycle and the
    // write lands on the edge that ends it, never on an earlier one.
    always_comb
    begin
        logic [2:0] idx;
        idx = cnt_index(req.addr);
        commit = i_psel && i_penable && pready_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        cfg_nxt = cfg_r;
        load = '0;
        for (int t = 0; t < NT; t++)
        begin
            load_val[t] = CW'(merge({16'h0000, count[t]}, req.wdata,
                                    req.strb));
        end
        if (i_psel && i_penable && !pready_r)
        begin
            pready_nxt = 1'b1;
            prdata_nxt = 32'h0000_0000;
            if (req.addr == ext_timer_pkg::OFF_CFG)
            begin
                prdata_nxt = cfg_r;
            end
            else if (idx < 3'(NT))
            begin
                prdata_nxt = {16'h0000, count[idx[1:0]]};
            end
            else
            begin
                pslverr_nxt = 1'b1;
            end
        end
        if (commit && req.write)
        begin
            if (req.addr == ext_timer_pkg::OFF_CFG)
            begin
                cfg_nxt = merge(cfg_r, req.wdata, req.strb);
            end
            else if (idx < 3'(NT) && req.strb[1:0] != 2'b00)
            begin
                load[idx[1:0]] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cfg_r <= ext_timer_pkg::CFG_RESET;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            baud_r <= 1'b0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            baud_r <= baud_nxt;
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_baud_ext_tick = baud_r;
endmodule : ext_timer_inputs
`default_nettype wire

// ### hdl/ext_timer_pkg.sv
/*
 * Shared constants and types of the external timer input block:
 * register offsets, reset values and the per-timer config layout.
 * Assumes an APB4 register bus with 32-bit data and byte strobes.
 */
package ext_timer_pkg;

    // ***************************************************************
    // Sizes
    // ***************************************************************
    localparam int unsigned N_TIMERS = 4;
    localparam int unsigned N_CLEAR = 2;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned CFG_W = 8;

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam logic [11:0] OFF_CFG = 12'h000;
    localparam logic [11:0] OFF_CNT1 = 12'h004;
    localparam logic [11:0] OFF_CNT2 = 12'h008;
    localparam logic [11:0] OFF_CNT3 = 12'h00c;
    localparam logic [11:0] OFF_CNT4 = 12'h010;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;

    // ***************************************************************
    // Config byte of one timer; timer n sits in byte n-1 of CFG
    // ***************************************************************
    localparam int unsigned FLD_EN = 0;
    localparam int unsigned FLD_UP = 1;
    localparam int unsigned FLD_CNT_EDGE = 2;
    localparam int unsigned FLD_CLR_EDGE = 4;
    localparam int unsigned FLD_BAUD_SEL = 6;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_e;

    typedef struct packed {
        logic spare;
        logic baud_sel;
        edge_e clr_edge;
        edge_e cnt_edge;
        logic up;
        logic en;
    } tmr_cfg_s;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
        logic [3:0] strb;
    } apb_req_s;

endpackage : ext_timer_pkg

// ### hdl/pin_edge_qualify.sv
/*
 * Brings one external pin into the core clock domain and flags the
 * edges that the edge selection asks for, one pulse per edge.
 * Assumes the pin is stable for at least two core clocks per level.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_edge_qualify (
    input wire logic i_core_clk, // Core clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_pin, // Raw external pin
    input wire ext_timer_pkg::edge_e i_sel, // Edges that count
    output logic o_hit // One-cycle pulse per edge
);
    logic meta_r;
    logic sync_r;
    logic prev_r;
    logic rise;
    logic fall;

    // ***************************************************************
    // Two-stage synchroniser plus history
    // ***************************************************************
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= i_pin; // [RULE8]
            sync_r <= meta_r; // [RULE8]
            prev_r <= sync_r;
        end
    end

    // Edge seen only on the settled stage, never on the first flop
    always_comb
    begin
        rise = sync_r && !prev_r;
        fall = !sync_r && prev_r;
        unique case (i_sel)
            ext_timer_pkg::EDGE_NONE: o_hit = 1'b0;
            ext_timer_pkg::EDGE_RISE: o_hit = rise;
            ext_timer_pkg::EDGE_FALL: o_hit = fall;
            ext_timer_pkg::EDGE_BOTH: o_hit = rise || fall;
        endcase
    end
endmodule : pin_edge_qualify
`default_nettype wire

// ### hdl/updown_counter.sv
/*
 * One up/down timer count register with software load and clear.
 * Assumes step and clear are single-cycle pulses in the core domain.
 */
`timescale 1ns/1ps
`default_nettype none
module updown_counter #(
    parameter int unsigned WIDTH = 16
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_en, // Counting allowed
    input wire logic i_up, // 1 counts up, 0 down
    input wire logic i_step, // Advance by one
    input wire logic i_clear, // Return to zero
    input wire logic i_load, // Software load
    input wire logic [WIDTH-1:0] i_load_val, // Value to load
    output logic [WIDTH-1:0] o_count // Current count
);
    logic [WIDTH-1:0] count_nxt;

    if (WIDTH < 2 || WIDTH > 32)
    begin : g_bad_width
        $error("updown_counter: WIDTH must be 2..32");
    end

    // Software load beats a clear, clear beats a step
    always_comb
    begin
        count_nxt = o_count;
        if (i_load)
        begin
            count_nxt = i_load_val;
        end
        else if (i_clear)
        begin
            count_nxt = '0;
        end
        else if (i_en && i_step)
        begin
            count_nxt = i_up ? o_count + 1'b1 : o_count - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_count <= '0;
        end
        else
        begin
            o_count <= count_nxt;
        end
    end
endmodule : updown_counter
`default_nettype wire

// ### tb/ext_timer_inputs_props.sv
/*
 * Concurrent checks of the external timer input block, bound to it.
 * Assumes pins hold each level for two core clocks or more.
 */
`timescale 1ns/1ps
`default_nettype none
module ext_timer_inputs_props (
    input wire logic i_core_clk, // Core clock
    input wire logic i_nrst, // Async reset, active low
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB access phase
    input wire logic i_pwrite, // APB direction
    input wire logic o_pready, // APB ready
    input wire logic o_pslverr, // APB error
    input wire logic i_timer_one_ext_count_in, // Count pin 1
    input wire logic i_timer_two_ext_count_in, // Count pin 2
    input wire logic i_timer_three_ext_count_in, // Count pin 3
    input wire logic i_timer_four_ext_count_in, // Count pin 4
    input wire logic i_timer_one_ext_clear_in, // Clear pin 1
    input wire logic i_timer_two_ext_clear_in, // Clear pin 2
    input wire logic o_baud_ext_tick, // Baud pulse
    input wire logic [63:0] o_timer_counts // Counts
);
    // ***************************************************************
    // Helpers and checks
    // ***************************************************************
    logic wr_ok, p1, p2, p3, p4, r1, r2;
    logic [15:0] c1, c2, c3, c4;
    assign wr_ok = i_psel & i_penable & o_pready & i_pwrite;
    assign {c4, c3, c2, c1} = o_timer_counts;
    assign p1 = i_timer_one_ext_count_in;
    assign p2 = i_timer_two_ext_count_in;
    assign p3 = i_timer_three_ext_count_in;
    assign p4 = i_timer_four_ext_count_in;
    assign r1 = i_timer_one_ext_clear_in;
    assign r2 = i_timer_two_ext_clear_in;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    // Software loads are the only other source of a count change
    AST_CNT1_SOURCE: assert property (
        $changed(c1) && !$past(wr_ok) |-> (c1 == $past(c1) + 16'h1
        || c1 == $past(c1) - 16'h1 || c1 == 16'h0)
        && ($past(p1, 3) != $past(p1, 4) || $past(r1, 3) != $past(r1, 4)))
        else $error("timer 1 count moved without its pin edge");
    AST_CNT2_SOURCE: assert property (
        $changed(c2) && !$past(wr_ok) |-> (c2 == $past(c2) + 16'h1
        || c2 == $past(c2) - 16'h1 || c2 == 16'h0)
        && ($past(p2, 3) != $past(p2, 4) || $past(r2, 3) != $past(r2, 4)))
        else $error("timer 2 count moved without its pin edge");
    AST_CNT3_SOURCE: assert property (
        $changed(c3) && !$past(wr_ok) |-> (c3 == $past(c3) + 16'h1
        || c3 == $past(c3) - 16'h1) && $past(p3, 3) != $past(p3, 4))
        else $error("timer 3 count moved without its pin edge");
    AST_CNT4_SOURCE: assert property (
        $changed(c4) && !$past(wr_ok) |-> (c4 == $past(c4) + 16'h1
        || c4 == $past(c4) - 16'h1) && $past(p4, 3) != $past(p4, 4))
        else $error("timer 4 count moved without its pin edge");
    AST_BAUD_CAUSE: assert property (
        o_baud_ext_tick |-> $past(p2, 3) != $past(p2, 4))
        else $error("baud tick without a timer 2 pin edge");
    AST_BAUD_PULSE: assert property (
        o_baud_ext_tick |=> !o_baud_ext_tick)
        else $error("baud tick longer than one cycle");
    AST_READY_WAIT: assert property (
        i_psel && $rose(i_penable) |=> o_pready)
        else $error("ready not after one wait state");
    AST_READY_PULSE: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    AST_ERR_PAIR: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    cover property (o_baud_ext_tick);
    cover property (o_pslverr);
    cover property ($changed(c1) && c1 == 16'h0);
endmodule : ext_timer_inputs_props
bind ext_timer_inputs ext_timer_inputs_props u_props (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_timer_one_ext_count_in(i_timer_one_ext_count_in),
    .i_timer_two_ext_count_in(i_timer_two_ext_count_in),
    .i_timer_three_ext_count_in(i_timer_three_ext_count_in),
    .i_timer_four_ext_count_in(i_timer_four_ext_count_in),
    .i_timer_one_ext_clear_in(i_timer_one_ext_clear_in),
    .i_timer_two_ext_clear_in(i_timer_two_ext_clear_in),
    .o_baud_ext_tick(o_baud_ext_tick), .o_timer_counts(o_timer_counts)
);
`default_nettype wire

// ### tb/ext_pin_source.sv
/*
 * External signal source driving the six timer pins as plain levels.
 * Assumes the caller picks a hold of two core clocks or more.
 */
`timescale 1ns/1ps
`default_nettype none
module ext_pin_source (
    input wire logic i_core_clk, // Core clock
    output logic [5:0] o_pins // Count pins 1-4, clear pins 1-2
);
    initial o_pins = 6'h00;
    // Shorter holds could be lost in the receiver's synchroniser
    task automatic flip(input int idx, input int hold);
        @(posedge i_core_clk);
        o_pins[idx] <= ~o_pins[idx];
        repeat (hold) @(posedge i_core_clk);
    endtask : flip
endmodule : ext_pin_source
`default_nettype wire

// ### tb/test_timer_external_clock_reset_inputs.sv
/*
 * Self-checking bench of the external timer inputs over APB.
 * Assumes the pin source model and the bound checker are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module test_timer_external_clock_reset_inputs;
    typedef struct packed {
        logic [2:0] t;
        logic [2:0] pin;
        logic [7:0] cfg;
        logic [15:0] ld;
        logic [3:0] n;
        logic [15:0] exp;
    } row_s;
    logic clk, nrst, psel, pen, pwr, pready, perr, err, tick;
    logic [11:0] addr;
    logic [31:0] wdat, prdata, rd;
    logic [3:0] strb;
    logic [5:0] pins;
    logic [63:0] cnts;
    row_s rows [0:9];
    int n_fail = 0;
    int check_count = 0;
    int ticks = 0;

    ext_timer_inputs dut (
        .i_core_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .i_pstrb(strb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
        .i_timer_one_ext_count_in(pins[0]),
        .i_timer_two_ext_count_in(pins[1]),
        .i_timer_three_ext_count_in(pins[2]),
        .i_timer_four_ext_count_in(pins[3]),
        .i_timer_one_ext_clear_in(pins[4]),
        .i_timer_two_ext_clear_in(pins[5]),
        .o_baud_ext_tick(tick), .o_timer_counts(cnts)
    );
    ext_pin_source src (.i_core_clk(clk), .o_pins(pins));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;

    task automatic check(input string what, input logic [63:0] seen,
        input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdat <= d;
        strb <= s;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        check("ready", pready, 1'b1);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic complete_run;
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial
    begin
        {nrst, psel, pen, pwr, addr, wdat, strb} = '0;
        rows = '{
            '{3'd1, 3'd0, 8'h07, 16'h0000, 4'd4, 16'h0002},
            '{3'd2, 3'd1, 8'h09, 16'h0010, 4'd4, 16'h000e},
            '{3'd3, 3'd2, 8'h0f, 16'h0000, 4'd4, 16'h0004},
            '{3'd4, 3'd3, 8'h0d, 16'h0000, 4'd3, 16'hfffd},
            '{3'd1, 3'd0, 8'h03, 16'h0007, 4'd4, 16'h0007},
            '{3'd1, 3'd4, 8'h10, 16'h0055, 4'd1, 16'h0000},
            '{3'd1, 3'd4, 8'h10, 16'h0055, 4'd1, 16'h0055},
            '{3'd1, 3'd4, 8'h20, 16'h0055, 4'd2, 16'h0000},
            '{3'd2, 3'd5, 8'h21, 16'h0033, 4'd1, 16'h0033},
            '{3'd2, 3'd5, 8'h31, 16'h0044, 4'd1, 16'h0000}};
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check("counts after reset", cnts, 64'h0);
        apb(1'b0, ext_timer_pkg::OFF_CFG, 32'h0, 4'h0);
        check("config reset", rd, ext_timer_pkg::CFG_RESET);
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b1, ext_timer_pkg::OFF_CNT1 + 12'(4 * (rows[i].t - 1)),
                {16'h0, rows[i].ld}, 4'hf);
            apb(1'b1, ext_timer_pkg::OFF_CFG,
                {24'h0, rows[i].cfg} << (8 * (rows[i].t - 1)), 4'hf);
            repeat (rows[i].n) src.flip(int'(rows[i].pin), 2 + i % 3);
            repeat (4) @(posedge clk);
            apb(1'b0, ext_timer_pkg::OFF_CNT1 + 12'(4 * (rows[i].t - 1)),
                32'h0, 4'h0);
            check("count read", rd, {16'h0, rows[i].exp});
            check("count port", cnts[16 * (rows[i].t - 1) +: 16],
                rows[i].exp);
        end
        // Lanes 0 and 1 off: the load must be dropped
        apb(1'b1, ext_timer_pkg::OFF_CNT1, 32'h0000_ffff, 4'hc);
        check("count kept", cnts[15:0], 16'h0000);
        apb(1'b0, 12'h014, 32'h0, 4'h0);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        // An unmapped write is refused and must not reach any count
        apb(1'b1, 12'h014, 32'hffff_ffff, 4'hf);
        check("unmapped write error", err, 1'b1);
        check("unmapped write kept", cnts, 64'hfffd_0004_0000_0000);
        apb(1'b1, ext_timer_pkg::OFF_CFG, 32'h0000_4400, 4'hf);
        repeat (4) src.flip(1, 3);
        repeat (4) @(posedge clk);
        check("baud ticks", ticks, 2);
        check("disabled count", cnts[31:16], 16'h0000);
        apb(1'b1, ext_timer_pkg::OFF_CFG, 32'h0000_0400, 4'hf);
        repeat (2) src.flip(1, 2);
        repeat (4) @(posedge clk);
        check("baud off", ticks, 2);
        // Only lane 3 written: timer 4 byte changes, the rest is kept
        apb(1'b1, ext_timer_pkg::OFF_CFG, 32'haa00_0000, 4'h8);
        apb(1'b0, ext_timer_pkg::OFF_CFG, 32'h0, 4'h0);
        check("config lane merge", rd, 32'haa00_0400);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check("counts after reset", cnts, 64'h0);
        apb(1'b0, ext_timer_pkg::OFF_CFG, 32'h0, 4'h0);
        check("config after reset", rd, ext_timer_pkg::CFG_RESET);
        complete_run();
    end
endmodule : test_timer_external_clock_reset_inputs
`default_nettype wire
